// *** hw/fda_pkg.sv ***
`default_nettype none
package fda_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] FDA_CTRL_OFS   = 12'h000;
  localparam logic [11:0] FDA_INSTR_OFS  = 12'h004;
  localparam logic [11:0] FDA_DADDR_OFS  = 12'h008;
  localparam logic [11:0] FDA_GR_L_OFS   = 12'h00c;
  localparam logic [11:0] FDA_GR_T_OFS   = 12'h010;
  localparam logic [11:0] FDA_GR_X_OFS   = 12'h014;
  localparam logic [11:0] FDA_GR_B_OFS   = 12'h018;
  localparam logic [11:0] FDA_STATUS_OFS = 12'h01c;
  localparam logic [11:0] FDA_EFF_OFS    = 12'h020;
  localparam logic [11:0] FDA_DESC_OFS   = 12'h024;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FDA_CTRL_GO_BIT    = 0;
  localparam int FDA_INSTR_SX_LSB   = 0;
  localparam int FDA_INSTR_RX_LSB   = 3;
  localparam int FDA_INSTR_OP_LSB   = 16;
  localparam int FDA_ST_BUSY_BIT    = 0;
  localparam int FDA_ST_DONE_BIT    = 1;
  localparam int FDA_ST_ILLEGAL_BIT = 2;
  localparam int FDA_ST_OVF_BIT     = 3;
  localparam int FDA_W2_POS_LSB     = 12;
  localparam int FDA_W2_LEN_LSB     = 8;
  localparam int FDA_W2_CNT_LSB     = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] FDA_WORD_RST  = 16'h0000;
  localparam logic [18:0] FDA_INSTR_RST = 19'h00009;
  localparam logic [19:0] FDA_EFF_RST   = 20'h00000;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam logic [2:0] FDA_SX_NONE = 3'h0;
  localparam logic [2:0] FDA_SX_INC  = 3'h1;
  localparam logic [2:0] FDA_SX_DEC  = 3'h7;
  localparam logic [2:0] FDA_RX_NONE = 3'h1;
  localparam logic [2:0] FDA_RX_L    = 3'h2;
  localparam logic [2:0] FDA_RX_T    = 3'h3;
  localparam logic [2:0] FDA_RX_X    = 3'h4;
  localparam logic [2:0] FDA_RX_B    = 3'h5;

  typedef enum logic [2:0] {
    load_field_zero_extend,
    load_field_sign_extend,
    store_field_from_accumulator,
    clear_field,
    set_field_ones,
    compare_field_unsigned,
    compare_field_signed,
    sense_leftmost_field_bit
  } fda_op_t;

endpackage
`default_nettype wire

// *** hw/fda_desc_step.sv ***
`timescale 1ns/1ps
`default_nettype none
module fda_desc_step #(
  parameter bit DOWN = 1'b0
) (
  input  wire logic [15:0] word1_in,
  input  wire logic [15:0] word2_in,
  output logic      [15:0] word1_out,
  output logic      [15:0] word2_out
);
  import fda_pkg::*;

  logic [19:0] start;
  logic [19:0] width;
  logic [19:0] moved;
  logic [7:0]  count;

  always_comb
  begin
    start = {word1_in, word2_in[FDA_W2_POS_LSB +: 4]};
    width = {16'h0000, word2_in[FDA_W2_LEN_LSB +: 4]} + 20'h00001;
    moved = DOWN ? start - width : start + width;
    // Count wraps in its own 8 bits, so the length nibble never changes
    count = DOWN ? word2_in[FDA_W2_CNT_LSB +: 8] - 8'h01
                 : word2_in[FDA_W2_CNT_LSB +: 8] + 8'h01;
    word1_out = moved[19:4];
    word2_out = {moved[3:0], word2_in[FDA_W2_LEN_LSB +: 4], count};
  end
endmodule // fda_desc_step
`default_nettype wire

// *** hw/fda_reg_index.sv ***
`timescale 1ns/1ps
`default_nettype none
module fda_reg_index (
  input  wire logic [2:0]  rx,
  input  wire logic [15:0] word_in,
  input  wire logic [15:0] gr_l,
  input  wire logic [15:0] gr_t,
  input  wire logic [15:0] gr_x,
  input  wire logic [15:0] gr_b,
  output logic      [15:0] word_out
);
  import fda_pkg::*;

  always_comb
  begin
    case (rx)
      FDA_RX_L: word_out = word_in + gr_l;
      FDA_RX_T: word_out = word_in + gr_t;
      FDA_RX_X: word_out = word_in + gr_x;
      FDA_RX_B: word_out = word_in + gr_b;
      default:  word_out = word_in;
    endcase
  end
endmodule // fda_reg_index
`default_nettype wire

// *** hw/fda_field_descriptor_address_unit.sv ***
// Behaviour
// - Self-index code only none, increment, decrement
// - Index code 001 off, 010-101 pick register
// - Opcode selects one of eight field operations
// - Second word address points at descriptor word one
// - No interrupt between the two instruction words
// - Descriptor may start at any word
// - No indexing: leading twenty bits pass unchanged
// - Address is word address plus bit position
// - Length code is field width minus one
// - Eight-bit count for loops or stack full
// - Increment adds width, bumps count, writes back
// - Count wraps modulo 256, length unchanged
// - Non-compare overflow set when incremented count zero
// - Compare overflow follows only comparison result
// - Increment without indexing uses written-back address
// - Register index adds to word address only
// - Indexing uses incremented descriptor when incrementing
// - Decrement written back after operation, address unchanged
// - Indexed sum never written to descriptor
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fda_field_descriptor_address_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [15:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic             fop_start,
  output var fda_pkg::fda_op_t fop_code,
  output logic      [19:0] fop_addr,
  output logic      [3:0]  fop_len,
  input  wire logic        fop_done,
  input  wire logic        fop_cmp_ovf,
  output logic             irq_inhibit,
  output logic             overflow
);
  import fda_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH1, ST_FETCH2, ST_CALC, ST_WB1, ST_WB2,
    ST_ADDR, ST_FOP, ST_WAIT, ST_DEC, ST_DWB1, ST_DWB2, ST_DONE
  } fda_state_t;

  typedef struct packed {
    fda_state_t  state;
    logic [18:0] instr;
    logic [15:0] daddr;
    logic [15:0] gr_l;
    logic [15:0] gr_t;
    logic [15:0] gr_x;
    logic [15:0] gr_b;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [19:0] eff;
    logic        ovf;
    logic        illegal;
    logic        done;
    logic        mem_req;
    logic        mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic        fop_start;
    logic        irq_inhibit;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fda_regs_t;

  fda_regs_t q;
  fda_regs_t d;
  logic [2:0]  sx;
  logic [2:0]  rx;
  fda_op_t     op;
  logic        is_cmp;
  logic        legal;
  logic        wr_acc;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [15:0] inc_w1;
  logic [15:0] inc_w2;
  logic [15:0] dec_w1;
  logic [15:0] dec_w2;
  logic [15:0] idx_word;

  assign sx     = q.instr[FDA_INSTR_SX_LSB +: 3];
  assign rx     = q.instr[FDA_INSTR_RX_LSB +: 3];
  assign op     = fda_op_t'(q.instr[FDA_INSTR_OP_LSB +: 3]);
  assign is_cmp = (op == compare_field_unsigned) || (op == compare_field_signed);
  // The E and A index registers are not served here, so those codes are refused
  assign legal  = (sx == FDA_SX_NONE || sx == FDA_SX_INC || sx == FDA_SX_DEC)
                && (rx >= FDA_RX_NONE && rx <= FDA_RX_B);
  assign wr_acc = psel && penable && q.pready && pwrite && !q.pslverr;

  // ****************************************
  // Descriptor arithmetic
  // ****************************************
  fda_desc_step #(.DOWN(1'b0)) u_inc (
    .word1_in  (q.w1),
    .word2_in  (q.w2),
    .word1_out (inc_w1),
    .word2_out (inc_w2)
  );
  fda_desc_step #(.DOWN(1'b1)) u_dec (
    .word1_in  (q.w1),
    .word2_in  (q.w2),
    .word1_out (dec_w1),
    .word2_out (dec_w2)
  );
  fda_reg_index u_idx (
    .rx       (rx),
    .word_in  (q.w1),
    .gr_l     (q.gr_l),
    .gr_t     (q.gr_t),
    .gr_x     (q.gr_x),
    .gr_b     (q.gr_b),
    .word_out (idx_word)
  );

  // ****************************************
  // Register read decode
  // ****************************************
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      FDA_CTRL_OFS:   rd_mux = 32'h00000000;
      FDA_INSTR_OFS:  rd_mux = {13'h0000, q.instr};
      FDA_DADDR_OFS:  rd_mux = {16'h0000, q.daddr};
      FDA_GR_L_OFS:   rd_mux = {16'h0000, q.gr_l};
      FDA_GR_T_OFS:   rd_mux = {16'h0000, q.gr_t};
      FDA_GR_X_OFS:   rd_mux = {16'h0000, q.gr_x};
      FDA_GR_B_OFS:   rd_mux = {16'h0000, q.gr_b};
      FDA_STATUS_OFS:
      begin
        rd_mux[FDA_ST_BUSY_BIT]    = (q.state != ST_IDLE);
        rd_mux[FDA_ST_DONE_BIT]    = q.done;
        rd_mux[FDA_ST_ILLEGAL_BIT] = q.illegal;
        rd_mux[FDA_ST_OVF_BIT]     = q.ovf;
      end
      FDA_EFF_OFS:    rd_mux = {12'h000, q.eff};
      FDA_DESC_OFS:   rd_mux = {q.w1, q.w2};
      default:        mapped = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d           = q;
    d.fop_start = 1'b0;
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;
    // One wait-free access: pready rises in the access phase
    if (psel && !penable)
    begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      d.prdata  = pwrite ? 32'h00000000 : rd_mux;
    end
    // Operand registers are frozen while a sequence runs
    if (wr_acc && q.state == ST_IDLE)
    begin
      case (paddr)
        FDA_INSTR_OFS: d.instr = pwdata[18:0];
        FDA_DADDR_OFS: d.daddr = pwdata[15:0];
        FDA_GR_L_OFS:  d.gr_l  = pwdata[15:0];
        FDA_GR_T_OFS:  d.gr_t  = pwdata[15:0];
        FDA_GR_X_OFS:  d.gr_x  = pwdata[15:0];
        FDA_GR_B_OFS:  d.gr_b  = pwdata[15:0];
        FDA_CTRL_OFS:
        begin
          if (pwdata[FDA_CTRL_GO_BIT])
          begin
            d.done    = !legal;
            d.illegal = !legal;
            if (legal)
            begin
              d.state       = ST_FETCH1;
              d.irq_inhibit = 1'b1;
              d.mem_req     = 1'b1;
              d.mem_we      = 1'b0;
              d.mem_addr    = q.daddr;
            end
          end
        end
        default: d.done = q.done;
      endcase
    end
    case (q.state)
      ST_IDLE: d.irq_inhibit = d.irq_inhibit;
      ST_FETCH1:
        if (mem_ack)
        begin
          d.w1       = mem_rdata;
          d.mem_addr = q.mem_addr + 16'h0001;
          d.state    = ST_FETCH2;
        end
      ST_FETCH2:
        if (mem_ack)
        begin
          d.w2      = mem_rdata;
          d.mem_req = 1'b0;
          d.state   = ST_CALC;
        end
      ST_CALC:
        if (sx == FDA_SX_INC)
        begin
          d.w1        = inc_w1;
          d.w2        = inc_w2;
          d.mem_req   = 1'b1;
          d.mem_we    = 1'b1;
          d.mem_addr  = q.daddr;
          d.mem_wdata = inc_w1;
          d.state     = ST_WB1;
        end
        else
        begin
          d.state = ST_ADDR;
        end
      ST_WB1:
        if (mem_ack)
        begin
          d.mem_addr  = q.daddr + 16'h0001;
          d.mem_wdata = q.w2;
          d.state     = ST_WB2;
        end
      ST_WB2:
        if (mem_ack)
        begin
          d.mem_req = 1'b0;
          d.mem_we  = 1'b0;
          d.state   = ST_ADDR;
        end
      ST_ADDR:
      begin
        // Index result goes to the address only; the stored words stay
        d.eff       = {idx_word, q.w2[FDA_W2_POS_LSB +: 4]};
        d.fop_start = 1'b1;
        d.state     = ST_FOP;
      end
      ST_FOP:  d.state = ST_WAIT;
      ST_WAIT:
        if (fop_done)
        begin
          if (is_cmp)
            d.ovf = fop_cmp_ovf;
          else
            d.ovf = (sx == FDA_SX_INC) && (q.w2[FDA_W2_CNT_LSB +: 8] == 8'h00);
          d.state = (sx == FDA_SX_DEC) ? ST_DEC : ST_DONE;
        end
      ST_DEC:
      begin
        d.w1        = dec_w1;
        d.w2        = dec_w2;
        d.mem_req   = 1'b1;
        d.mem_we    = 1'b1;
        d.mem_addr  = q.daddr;
        d.mem_wdata = dec_w1;
        d.state     = ST_DWB1;
      end
      ST_DWB1:
        if (mem_ack)
        begin
          d.mem_addr  = q.daddr + 16'h0001;
          d.mem_wdata = q.w2;
          d.state     = ST_DWB2;
        end
      ST_DWB2:
        if (mem_ack)
        begin
          d.mem_req = 1'b0;
          d.mem_we  = 1'b0;
          d.state   = ST_DONE;
        end
      ST_DONE:
      begin
        d.done        = 1'b1;
        d.irq_inhibit = 1'b0;
        d.state       = ST_IDLE;
      end
      default: d.state = ST_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q       <= '0;
      q.state <= ST_IDLE;
      q.instr <= FDA_INSTR_RST;
      q.eff   <= FDA_EFF_RST;
      q.w1    <= FDA_WORD_RST;
      q.w2    <= FDA_WORD_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata      = q.prdata;
  assign pready      = q.pready;
  assign pslverr     = q.pslverr;
  assign mem_req     = q.mem_req;
  assign mem_we      = q.mem_we;
  assign mem_addr    = q.mem_addr;
  assign mem_wdata   = q.mem_wdata;
  assign fop_start   = q.fop_start;
  assign fop_code    = op;
  assign fop_addr    = q.eff;
  assign fop_len     = q.w2[FDA_W2_LEN_LSB +: 4];
  assign irq_inhibit = q.irq_inhibit;
  assign overflow    = q.ovf;
endmodule // fda_field_descriptor_address_unit
`default_nettype wire

// *** verif/fda_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Main memory and field operation responder
// ****************************************
module fda_mem_model (
  input  wire logic        pclk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata,
  input  wire logic        fop_start,
  output logic             fop_done,
  output logic             fop_cmp_ovf,
  input  wire logic [1:0]  slow,
  input  wire logic        cmp_res
);
  logic [15:0] mem [0:65535];
  logic [1:0]  wait_q = 2'h0;
  logic [2:0]  fcnt_q = 3'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0;
  initial fop_done = 1'b0;
  initial fop_cmp_ovf = 1'b0;
  // Idle data lines toggle so a stale word is never mistaken for a fresh one
  always @(posedge pclk)
  begin
    mem_ack     <= 1'b0;
    mem_rdata   <= ~mem_rdata;
    fop_done    <= 1'b0;
    fop_cmp_ovf <= ~fop_cmp_ovf;
    if (mem_req && !mem_ack)
    begin
      wait_q <= wait_q - 2'h1;
      if (wait_q == 2'h0)
      begin
        mem_ack <= 1'b1;
        wait_q  <= slow;
        if (mem_we)
          mem[mem_addr] <= mem_wdata;
        else
          mem_rdata <= mem[mem_addr];
      end
    end
    if (fop_start)
      fcnt_q <= {1'b0, slow} + 3'h2;
    else if (fcnt_q != 3'h0)
      fcnt_q <= fcnt_q - 3'h1;
    if (fcnt_q == 3'h1)
    begin
      fop_done    <= 1'b1;
      fop_cmp_ovf <= cmp_res;
    end
  end
endmodule // fda_mem_model
`default_nettype wire

// *** verif/fda_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module fda_sva
  import fda_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic        fop_start,
  input wire fda_op_t     fop_code,
  input wire logic [19:0] fop_addr,
  input wire logic [3:0]  fop_len,
  input wire logic        fop_done,
  input wire logic        fop_cmp_ovf,
  input wire logic        irq_inhibit,
  input wire logic        overflow
);
  logic [2:0]       t_q, sx_q, rx_q;
  logic [15:0]      da_q;
  logic [1:0][15:0] xf_q;
  logic [19:0]      sa0, wid, nsa, base;
  logic [7:0]       cnt;
  logic             acc, legal;
  // Reference descriptor arithmetic rebuilt from the words actually fetched
  assign acc   = psel && penable && pready && pwrite && !irq_inhibit;
  assign legal = sx_q inside {FDA_SX_NONE, FDA_SX_INC, FDA_SX_DEC} && rx_q inside {[1:5]};
  assign sa0   = {xf_q[0], xf_q[1][15:12]};
  assign wid   = {16'h0, xf_q[1][11:8]} + 20'h1;
  assign nsa   = (sx_q == FDA_SX_INC) ? sa0 + wid : sa0 - wid;
  assign cnt   = xf_q[1][7:0] + ((sx_q == FDA_SX_INC) ? 8'h01 : 8'hff);
  assign base  = (sx_q == FDA_SX_INC) ? nsa : sa0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      t_q  <= 3'h0;
      sx_q <= FDA_INSTR_RST[2:0];
      rx_q <= FDA_INSTR_RST[5:3];
      da_q <= 16'h0;
      xf_q <= '0;
    end
    else
    begin
      if (acc && paddr == FDA_INSTR_OFS)
      begin
        sx_q <= pwdata[2:0];
        rx_q <= pwdata[5:3];
      end
      if (acc && paddr == FDA_DADDR_OFS)
        da_q <= pwdata[15:0];
      if (acc && paddr == FDA_CTRL_OFS)
        t_q <= 3'h0;
      else if (mem_req && mem_ack)
      begin
        if (t_q < 3'h2)
          xf_q[t_q[0]] <= mem_rdata;
        t_q <= t_q + 3'h1;
      end
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ack0;
    mem_req && mem_ack && t_q == 3'h0;
  endsequence
  sequence s_cmp_done;
    fop_done && fop_code inside {compare_field_unsigned, compare_field_signed};
  endsequence
  property p_rd1;
    mem_req && t_q == 3'h0 |-> !mem_we && mem_addr == da_q;
  endproperty
  a_rd1: assert property (p_rd1) else $error("first fetch address wrong");
  property p_rd2;
    s_ack0 ##1 mem_req |-> !mem_we && mem_addr == da_q + 16'h1;
  endproperty
  a_rd2: assert property (p_rd2) else $error("second fetch address wrong");
  property p_eff;
    fop_start && rx_q == FDA_RX_NONE |-> fop_addr == base;
  endproperty
  a_eff: assert property (p_eff) else $error("unindexed field address wrong");
  property p_pos;
    fop_start |-> fop_addr[3:0] == base[3:0] && fop_len == xf_q[1][11:8];
  endproperty
  a_pos: assert property (p_pos) else $error("bit position or length wrong");
  property p_order;
    fop_start |-> irq_inhibit && t_q == ((sx_q == FDA_SX_INC) ? 3'h4 : 3'h2);
  endproperty
  a_order: assert property (p_order) else $error("write-back order wrong");
  property p_wb;
    mem_req && mem_ack && mem_we |->
      mem_wdata == ((t_q == 3'h2) ? nsa[19:4] : {nsa[3:0], xf_q[1][11:8], cnt});
  endproperty
  a_wb: assert property (p_wb) else $error("descriptor write-back wrong");
  property p_ovf;
    fop_done && !(fop_code inside {compare_field_unsigned, compare_field_signed})
      |=> overflow == (sx_q == FDA_SX_INC && cnt == 8'h00);
  endproperty
  a_ovf: assert property (p_ovf) else $error("count overflow wrong");
  property p_cmp;
    s_cmp_done |=> overflow == $past(fop_cmp_ovf);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare overflow wrong");
  property p_bad;
    acc && paddr == FDA_CTRL_OFS && pwdata[0] && !legal |=> !mem_req [*4];
  endproperty
  a_bad: assert property (p_bad) else $error("illegal code started a fetch");
endmodule // fda_sva
bind fda_field_descriptor_address_unit fda_sva u_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .paddr, .pwdata, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
  .mem_rdata, .fop_start, .fop_code, .fop_addr, .fop_len, .fop_done, .fop_cmp_ovf,
  .irq_inhibit, .overflow);
`default_nettype wire

// *** verif/test_field_descriptor_address_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_field_descriptor_address_unit;
  import fda_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we;
  logic        mem_ack, fop_start, fop_done, fop_cmp_ovf, irq_inhibit, overflow, cmp_res;
  logic [1:0]  slow;
  logic [3:0]  fop_len;
  logic [11:0] paddr;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, d, w1, w2;
  logic [15:0] gr [4];
  logic [19:0] fop_addr;
  logic [31:0] pwdata, prdata;
  logic [32:0] ex;
  logic [32:0] expq [$];
  fda_op_t     fop_code;
  integer      seed;
  int          mismatches, check_count, cycles;
  localparam logic [5:0] BAD [4] = '{6'h0a, 6'h00, 6'h30, 6'h39};
  fda_field_descriptor_address_unit uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .fop_start, .fop_code, .fop_addr, .fop_len, .fop_done, .fop_cmp_ovf,
    .irq_inhibit, .overflow);
  fda_mem_model mm (.pclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
    .fop_start, .fop_done, .fop_cmp_ovf, .slow, .cmp_res);
  always #50 pclk = ~pclk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Caller enters just after an edge; one idle edge follows each release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic run(input int i);
    logic [2:0]  sx, rx;
    logic [19:0] sa, wd, ns, b;
    logic [7:0]  c;
    logic        ov;
    sx = (i == 3 || i == 7) ? FDA_SX_DEC : (i == 0 || i == 5) ? FDA_SX_NONE : FDA_SX_INC;
    rx = (i < 2 || i == 6) ? FDA_RX_NONE : (i == 7) ? FDA_RX_L : 3'(i);
    d = (i == 7) ? 16'hffff : 16'($random(seed));
    w1 = 16'($random(seed));
    w2 = 16'($random(seed));
    if (i == 1 || i == 6)
      w2[7:0] = 8'hff;
    mm.mem[d] = w1;
    mm.mem[d + 16'h1] = w2;
    slow <= 2'($random(seed));
    cmp_res <= (i == 5);
    sa = {w1, w2[15:12]};
    wd = {16'h0, w2[11:8]} + 20'h1;
    ns = (sx == FDA_SX_INC) ? sa + wd : (sx == FDA_SX_DEC) ? sa - wd : sa;
    c = w2[7:0] + ((sx == FDA_SX_INC) ? 8'h01 : (sx == FDA_SX_DEC) ? 8'hff : 8'h00);
    b = (sx == FDA_SX_INC) ? ns : sa;
    if (rx != FDA_RX_NONE)
      b[19:4] = b[19:4] + gr[rx - 3'h2];
    ov = (i == 5 || i == 6) ? (i == 5) : (sx == FDA_SX_INC && c == 8'h00);
    apb(1'b1, FDA_INSTR_OFS, {13'h0, 3'(i), 10'h0, rx, sx});
    apb(1'b1, FDA_DADDR_OFS, {16'h0, d});
    apb(1'b1, FDA_CTRL_OFS, 32'h1);
    while (irq_inhibit !== 1'b0)
      @(posedge pclk);
    rd(FDA_EFF_OFS, {13'h0, b});
    rd(FDA_STATUS_OFS, {29'h0, ov, 3'h2});
    chk("fop_addr", {13'h0, fop_addr}, {13'h0, b});
    chk("overflow", {32'h0, overflow}, {32'h0, ov});
    chk("word1", {17'h0, mm.mem[d]}, {17'h0, ns[19:4]});
    chk("word2", {17'h0, mm.mem[d + 16'h1]}, {17'h0, ns[3:0], w2[11:8], c});
    chk("opcode", 33'(fop_code), 33'(i));
    chk("length", 33'(fop_len), {29'h0, w2[11:8]});
    $display("case %0d done", i);
  endtask
  // ****************************************
  // Result watcher and timeout
  // ****************************************
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      conclude();
    end
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      ex = expq.pop_front();
      chk("read", ex[32] ? {pslverr, 32'h0} : {pslverr, prdata}, ex);
    end
  end
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, cmp_res, slow} = '0;
    {paddr, pwdata, mismatches, check_count, cycles} = '0;
    seed = 32'he406;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(FDA_INSTR_OFS, 33'h9);
    rd(FDA_STATUS_OFS, 33'h0);
    rd(12'h028, {1'b1, 32'h0});
    for (int k = 0; k < 4; k++)
    begin
      gr[k] = 16'($random(seed));
      apb(1'b1, FDA_GR_L_OFS + 12'(4 * k), {16'h0, gr[k]});
    end
    // Bad codes go first while the overflow bit is still known to be clear
    foreach (BAD[k])
    begin
      apb(1'b1, FDA_INSTR_OFS, {26'h0, BAD[k]});
      apb(1'b1, FDA_CTRL_OFS, 32'h1);
      rd(FDA_STATUS_OFS, 33'h6);
    end
    $display("illegal codes done");
    for (int i = 0; i < 8; i++)
      run(i);
    conclude();
  end
endmodule // test_field_descriptor_address_unit
`default_nettype wire
